// file: fwsr_pkg.sv
/*
 Constants for the host-side flash status poller: status bit positions,
 read cycle timing and result codes.
 Assumes a 16-bit parallel flash with open-drain ready/busy output.
*/
package fwsr_pkg;
	localparam int unsigned CLK_PERIOD_NS = 10;
	localparam int unsigned DATA_W        = 16;
	// Status bit positions on the data lines
	localparam int unsigned POLL_BIT      = 7;
	localparam int unsigned TOGGLE1_BIT   = 6;
	localparam int unsigned LIMIT_BIT     = 5;
	localparam int unsigned ERTIMER_BIT   = 3;
	localparam int unsigned TOGGLE2_BIT   = 2;
	// Read strobe low time and recovery, in ns
	localparam int unsigned READ_LOW_NS   = 80;
	localparam int unsigned READ_GAP_NS   = 30;
	localparam int unsigned READ_LOW_CYC  = (READ_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned READ_GAP_CYC  = (READ_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0]  READ_LOW_C    = 8'(READ_LOW_CYC);
	localparam logic [7:0]  READ_GAP_C    = 8'(READ_GAP_CYC);
	// Reset command data word
	localparam logic [15:0] RESET_CMD     = 16'h00f0;
	// Result codes
	localparam logic [1:0]  RES_DONE      = 2'h0;
	localparam logic [1:0]  RES_FAIL      = 2'h1;
	localparam logic [1:0]  RES_ABORT     = 2'h2;
	// Polling methods
	localparam logic        MODE_TOGGLE   = 1'b0;
	localparam logic        MODE_POLL     = 1'b1;
endpackage

// file: fwsr_poller.sv
/*
 Host-side status poller for a parallel flash running embedded program or
 erase. Runs either the polling-bit or the toggle-bit check by issuing read
 cycles on the flash pins, and writes the reset command on a timing failure.
 Assumes the flash data and ready/busy pin are synchronous to i_clk.
*/
// Summary of operation
// - Host reads status at program address or inside erased sector.
// - Host takes full data word only on a later read.
// - Host rechecks polling bit after seeing timing-limit flag set.
// - Host reads twice, compares toggle; stopped means done.
// - Toggling with limit flag set on recheck means fail; issue reset.
// - Host restarts toggle procedure from first step after an abort.
// - Host addresses busy bank for status; idle bank returns data.
`timescale 1ns/1ps
`default_nettype none
module fwsr_poller #(
	parameter int unsigned ADDR_W = 22
) (
	// Clock and reset
	input  wire logic                 i_clk,
	input  wire logic                 i_resetn,
	// User request
	input  wire logic                 i_start,
	input  wire logic                 i_mode,
	input  wire logic [ADDR_W-1:0]    i_addr,
	input  wire logic [7:0]           i_expect,
	input  wire logic                 i_abort,
	// User answer
	output logic                      o_busy,
	output logic                      o_done,
	output logic [1:0]                o_result,
	output logic [15:0]               o_data,
	output logic                      o_ready_level,
	// Flash pins
	output logic [ADDR_W-1:0]         o_flash_addr,
	output logic                      o_flash_oe_n,
	output logic                      o_flash_we_n,
	output logic [15:0]               o_flash_dq_out,
	output logic                      o_flash_dq_oe,
	input  wire logic [15:0]          i_flash_dq_in,
	input  wire logic                 i_ready_busy_pin
);
	typedef enum logic [2:0] {
		FWSR_IDLE  = 3'b000,
		FWSR_LOW   = 3'b001,
		FWSR_GAP   = 3'b010,
		FWSR_EVAL  = 3'b011,
		FWSR_WRITE = 3'b100,
		FWSR_FIN   = 3'b101
	} fwsr_state_e;
	typedef struct packed {
		fwsr_state_e          st;
		logic [7:0]           cnt;
		logic                 mode;
		logic [7:0]           expect_b;
		logic [ADDR_W-1:0]    addr;
		logic [15:0]          prev;
		logic [15:0]          cur;
		logic                 have_prev;
		logic                 limit_seen;
		logic                 final_read;
		logic                 busy;
		logic                 done;
		logic [1:0]           result;
		logic [15:0]          data;
		logic                 ready_level;
		logic                 oe_n;
		logic                 we_n;
		logic                 dq_oe;
	} fwsr_state_s;

	fwsr_state_s r;
	fwsr_state_s next_r;
	logic        pbit_true;
	logic        tog_same;
	// Compare helpers on the last captured words
	assign pbit_true = (r.cur[fwsr_pkg::POLL_BIT] == r.expect_b[fwsr_pkg::POLL_BIT]);
	assign tog_same  = (r.cur[fwsr_pkg::TOGGLE1_BIT] == r.prev[fwsr_pkg::TOGGLE1_BIT])
		&& (r.cur[fwsr_pkg::TOGGLE2_BIT] == r.prev[fwsr_pkg::TOGGLE2_BIT]);

	// Sequencer: read cycles, evaluation, reset command write
	always_comb
	begin
		next_r = r;
		next_r.done = 1'b0;
		next_r.ready_level = i_ready_busy_pin;
		if (r.cnt != 8'h00)
		begin
			next_r.cnt = r.cnt - 8'h01;
		end
		case (r.st)
			FWSR_IDLE:
			begin
				if (i_start)
				begin
					// Always from step one, even after an earlier abort
					next_r.mode = i_mode;
					next_r.expect_b = i_expect;
					next_r.addr = i_addr;
					next_r.have_prev = 1'b0;
					next_r.limit_seen = 1'b0;
					next_r.final_read = 1'b0;
					next_r.busy = 1'b1;
					next_r.oe_n = 1'b0;
					next_r.cnt = fwsr_pkg::READ_LOW_C;
					next_r.st = FWSR_LOW;
				end
			end
			FWSR_LOW:
			begin
				if (r.cnt == 8'h01)
				begin
					next_r.prev = r.cur;
					next_r.cur = i_flash_dq_in;
					next_r.oe_n = 1'b1; // Each read is a separate strobe so toggles advance
					next_r.cnt = fwsr_pkg::READ_GAP_C;
					next_r.st = FWSR_GAP;
				end
			end
			FWSR_GAP:
			begin
				if (r.cnt == 8'h01)
				begin
					next_r.st = FWSR_EVAL;
				end
			end
			FWSR_EVAL:
			begin
				next_r.have_prev = 1'b1;
				next_r.st = FWSR_LOW;
				next_r.oe_n = 1'b0;
				next_r.cnt = fwsr_pkg::READ_LOW_C;
				if (r.final_read)
				begin
					// Word from a read after completion is the good one
					next_r.data = r.cur;
					next_r.result = fwsr_pkg::RES_DONE;
					next_r.oe_n = 1'b1;
					next_r.st = FWSR_FIN;
				end
				else if (i_abort)
				begin
					next_r.result = fwsr_pkg::RES_ABORT;
					next_r.oe_n = 1'b1;
					next_r.st = FWSR_FIN;
				end
				else if (r.mode == fwsr_pkg::MODE_POLL)
				begin
					if (pbit_true)
					begin
						next_r.final_read = 1'b1;
					end
					else if (r.limit_seen)
					begin
						// Recheck already done after the limit flag
						next_r.oe_n = 1'b1;
						next_r.st = FWSR_WRITE;
					end
					else if (r.cur[fwsr_pkg::LIMIT_BIT])
					begin
						next_r.limit_seen = 1'b1;
					end
				end
				else if (r.have_prev)
				begin
					if (tog_same)
					begin
						next_r.final_read = 1'b1;
					end
					else if (r.limit_seen)
					begin
						next_r.oe_n = 1'b1;
						next_r.st = FWSR_WRITE;
					end
					else if (r.cur[fwsr_pkg::LIMIT_BIT])
					begin
						next_r.limit_seen = 1'b1;
					end
				end
			end
			FWSR_WRITE:
			begin
				// Reset command write strobe, then report failure
				if (r.we_n && !r.dq_oe)
				begin
					next_r.dq_oe = 1'b1;
					next_r.we_n = 1'b0;
					next_r.cnt = fwsr_pkg::READ_LOW_C;
				end
				else if (!r.we_n && r.cnt == 8'h01)
				begin
					next_r.we_n = 1'b1;
				end
				else if (r.we_n)
				begin
					next_r.dq_oe = 1'b0;
					next_r.result = fwsr_pkg::RES_FAIL;
					next_r.st = FWSR_FIN;
				end
			end
			FWSR_FIN:
			begin
				next_r.busy = 1'b0;
				next_r.done = 1'b1;
				next_r.st = FWSR_IDLE;
			end
			default:
			begin
				next_r.st = FWSR_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			r <= '{st: FWSR_IDLE, oe_n: 1'b1, we_n: 1'b1, ready_level: 1'b1, default: '0};
		end
		else
		begin
			r <= next_r;
		end
	end
	// Outputs straight from flops, except o_flash_dq_out, which is the constant RESET_CMD
	assign o_busy         = r.busy;
	assign o_done         = r.done;
	assign o_result       = r.result;
	assign o_data         = r.data;
	assign o_ready_level  = r.ready_level;
	assign o_flash_addr   = r.addr;
	assign o_flash_oe_n   = r.oe_n;
	assign o_flash_we_n   = r.we_n;
	assign o_flash_dq_out = fwsr_pkg::RESET_CMD;
	assign o_flash_dq_oe  = r.dq_oe;
	// Checks
	property p_fail_after_write;
		@(posedge i_clk) disable iff (!i_resetn)
		(r.st == FWSR_WRITE && !r.we_n) |-> ##[1:20] (r.result == fwsr_pkg::RES_FAIL && o_done);
	endproperty
	a_fail_after_write: assert property (p_fail_after_write) else $error("no fail after reset cmd");
	property p_no_drive_during_read;
		@(posedge i_clk) disable iff (!i_resetn)
		!o_flash_oe_n |-> !o_flash_dq_oe;
	endproperty
	a_no_drive_during_read: assert property (p_no_drive_during_read) else $error("bus clash");
	property p_write_needs_limit;
		@(posedge i_clk) disable iff (!i_resetn)
		$rose(r.st == FWSR_WRITE) |-> $past(r.limit_seen);
	endproperty
	a_write_needs_limit: assert property (p_write_needs_limit) else $error("reset without recheck");
	property p_ready_follows_pin;
		@(posedge i_clk) disable iff (!i_resetn)
		##1 1'b1 |-> o_ready_level == $past(i_ready_busy_pin);
	endproperty
	a_ready_follows_pin: assert property (p_ready_follows_pin) else $error("ready level stale");
	property p_read_width;
		@(posedge i_clk) disable iff (!i_resetn)
		$fell(o_flash_oe_n) |-> !o_flash_oe_n [*2];
	endproperty
	a_read_width: assert property (p_read_width) else $error("read strobe too short");
	property p_done_from_final;
		@(posedge i_clk) disable iff (!i_resetn)
		(o_done && o_result == fwsr_pkg::RES_DONE) |-> $past(r.final_read, 2);
	endproperty
	a_done_from_final: assert property (p_done_from_final) else $error("done without confirm read");
	property p_start_restarts;
		@(posedge i_clk) disable iff (!i_resetn)
		(r.st == FWSR_IDLE && i_start) |=> (!r.have_prev && !r.limit_seen);
	endproperty
	a_start_restarts: assert property (p_start_restarts) else $error("stale toggle history");
	property p_addr_held;
		@(posedge i_clk) disable iff (!i_resetn)
		(o_busy && $past(o_busy)) |-> $stable(o_flash_addr);
	endproperty
	a_addr_held: assert property (p_addr_held) else $error("address moved mid poll");

	c_done: cover property (@(posedge i_clk) o_done && o_result == fwsr_pkg::RES_DONE);
	c_fail: cover property (@(posedge i_clk) o_done && o_result == fwsr_pkg::RES_FAIL);
	c_abort: cover property (@(posedge i_clk) o_done && o_result == fwsr_pkg::RES_ABORT);
endmodule
`default_nettype wire

// file: fwsr_flash_model.sv
/*
 Behavioural flash model answering status reads for the poller bench.
 Assumes reads end on the clock edge where the read strobe rises.
*/
`timescale 1ns/1ps
`default_nettype none
module fwsr_flash_model (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_resetn,
	// Bench control
	input  wire logic        i_go,
	input  wire logic        i_erase,
	input  wire logic [7:0]  i_reads,
	input  wire logic        i_fail,
	input  wire logic [15:0] i_word,
	// Flash pins
	input  wire logic        i_oe_n,
	input  wire logic        i_we_n,
	input  wire logic        i_dq_oe,
	input  wire logic [15:0] i_dq,
	output logic [15:0]      o_dq,
	output logic             o_ready_busy,
	output logic [7:0]       o_resets
);
	logic        busy, t1, t2, oe_q, we_q;
	logic [7:0]  left;
	logic [15:0] stat, last;
	// Status word while busy, array word once idle
	always_comb
	begin
		stat    = i_word;
		stat[7] = i_erase ? 1'b0 : ~i_word[7];
		stat[6] = t1;
		stat[5] = i_fail;
		stat[3] = i_erase;
		stat[2] = i_erase & t2;
		if (!busy)
			stat = i_word;
	end
	// Released bus shows inverted data so a stale word never passes
	assign o_dq         = i_oe_n ? ~last : stat;
	assign o_ready_busy = ~busy;
	// Read ends move the toggles and the completion count
	always_ff @(posedge i_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			busy     <= 1'b0;
			t1       <= 1'b0;
			t2       <= 1'b0;
			oe_q     <= 1'b1;
			we_q     <= 1'b1;
			left     <= 8'h00;
			last     <= 16'h0000;
			o_resets <= 8'h00;
		end
		else
		begin
			oe_q <= i_oe_n;
			we_q <= i_we_n;
			if (!i_oe_n)
				last <= stat;
			if (i_go)
			begin
				busy <= 1'b1;
				left <= i_reads;
			end
			else if (!oe_q && i_oe_n && busy)
			begin
				t1   <= ~t1;
				t2   <= ~t2;
				left <= left - 8'h01;
				if (left == 8'h01 && !i_fail)
					busy <= 1'b0;
			end
			// Reset command ends a failed operation
			if (we_q && !i_we_n && i_dq_oe && i_dq == 16'h00f0)
			begin
				busy     <= 1'b0;
				o_resets <= o_resets + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// file: flash_write_status_reporting_tb.sv
/*
 Self-checking bench for the flash status poller with random operations.
 Assumes the flash model in fwsr_flash_model.sv.
*/
`timescale 1ns/1ps
`default_nettype none
module flash_write_status_reporting_tb;
	logic        i_clk, i_resetn, i_start, i_mode, i_abort;
	logic        o_busy, o_done, o_ready_level, oe_n, we_n, dq_oe, go, erase, fail_en, rb;
	logic [21:0] i_addr, faddr;
	logic [7:0]  i_expect, reads, resets;
	logic [1:0]  o_result;
	logic [15:0] o_data, dq_out, dq_in, word;
	int          fails = 0;
	int          comparisons = 0;
	int          cyc = 0;
	fwsr_poller #(.ADDR_W(22)) dut_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_start(i_start),
		.i_mode(i_mode), .i_addr(i_addr), .i_expect(i_expect), .i_abort(i_abort),
		.o_busy(o_busy), .o_done(o_done), .o_result(o_result), .o_data(o_data),
		.o_ready_level(o_ready_level), .o_flash_addr(faddr), .o_flash_oe_n(oe_n),
		.o_flash_we_n(we_n), .o_flash_dq_out(dq_out), .o_flash_dq_oe(dq_oe),
		.i_flash_dq_in(dq_in), .i_ready_busy_pin(rb));
	fwsr_flash_model model_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_go(go), .i_erase(erase),
		.i_reads(reads), .i_fail(fail_en), .i_word(word), .i_oe_n(oe_n), .i_we_n(we_n),
		.i_dq_oe(dq_oe), .i_dq(dq_out), .o_dq(dq_in), .o_ready_busy(rb), .o_resets(resets));
	// Clock
	initial
	begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	// Hang guard, far above the longest expected run
	always @(posedge i_clk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			fails++;
			results();
		end
	end
	task check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			fails++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	function automatic logic [1:0] exp_result(input logic f, input logic a);
		return a ? fwsr_pkg::RES_ABORT : (f ? fwsr_pkg::RES_FAIL : fwsr_pkg::RES_DONE);
	endfunction
	// One operation: load the model, start the poll, judge the outcome
	task run(input logic m, input logic e, input logic f, input logic a, input logic [7:0] r);
		logic [7:0] rs;
		int         n;
		rs = resets;
		word = 16'($urandom);
		word[7] = word[7] | e;
		erase = e;
		fail_en = f;
		reads = r;
		go = 1'b1;
		@(negedge i_clk);
		go = 1'b0;
		i_start = 1'b1;
		i_mode = m;
		i_addr = 22'($urandom);
		i_expect = word[7:0];
		@(negedge i_clk);
		i_start = 1'b0;
		@(negedge i_clk);
		check(16'({o_busy, o_ready_level}), 16'h0002);
		check(faddr[15:0], i_addr[15:0]);
		check(16'(faddr[21:16]), 16'(i_addr[21:16]));
		n = 0;
		while (o_done !== 1'b1 && n < 3000)
		begin
			@(negedge i_clk);
			n++;
			i_abort = a && n > 40;
		end
		check(16'(o_done), 16'h0001);
		check(16'(o_result), 16'(exp_result(f, a)));
		if (!f && !a)
			check(o_data, word);
		check(16'(resets - rs), 16'(f && !a));
		i_abort = 1'b0;
		repeat (2) @(negedge i_clk);
		check(16'({o_busy, o_ready_level | a}), 16'h0001);
	endtask
	task results;
		if (fails == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Reset, corner cases, then random operations
	initial
	begin
		{i_resetn, i_start, i_mode, i_abort, go, erase, fail_en} = 7'h00;
		{i_addr, i_expect, reads, word} = '0;
		void'($urandom(85501));
		repeat (2) @(negedge i_clk);
		check(16'({o_busy, o_done, oe_n, we_n, dq_oe, o_ready_level}), 16'h000d);
		i_resetn = 1'b1;
		run(fwsr_pkg::MODE_POLL, 1'b0, 1'b0, 1'b0, 8'h01);
		run(fwsr_pkg::MODE_TOGGLE, 1'b1, 1'b0, 1'b0, 8'h01);
		run(fwsr_pkg::MODE_TOGGLE, 1'b0, 1'b1, 1'b0, 8'h04);
		run(fwsr_pkg::MODE_POLL, 1'b1, 1'b1, 1'b0, 8'h04);
		run(fwsr_pkg::MODE_TOGGLE, 1'b0, 1'b0, 1'b1, 8'hc8);
		repeat (20)
			run(1'($urandom), 1'($urandom), 1'b0, 1'b0, 8'($urandom_range(1, 8)));
		results();
	end
endmodule
`default_nettype wire
